// [verilog/quasi_bidir_port_pair.sv]
// Two quasi-bidirectional 8-bit ports: upper address port and multi-function port.
// Assumes the core writes latches with one-cycle strobes on core_clk and that
// pad cells resolve strong_lo/strong_hi/weak_hi into a pin level.
`default_nettype none
module quasi_bidir_port_pair
    import qbp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Latch writes from the core
    input wire logic up_wr,
    input wire logic [PORT_W-1:0] up_wdata,
    input wire logic mf_wr,
    input wire logic [PORT_W-1:0] mf_wdata,
    // External bus address high byte
    input wire logic ext_bus_active,
    input wire logic ext_bus_fetch,
    input wire logic [PORT_W-1:0] ext_addr_hi,
    // Alternate function outputs, one enable per bit
    input wire logic [PORT_W-1:0] mf_alt_en,
    input wire logic [PORT_W-1:0] mf_alt_out,
    // Upper address port pins
    input wire logic [PORT_W-1:0] upper_address_port_pins_in,
    output logic [PORT_W-1:0] up_strong_lo,
    output logic [PORT_W-1:0] up_strong_hi,
    output logic [PORT_W-1:0] up_weak_hi,
    // Multi-function port pins
    input wire logic [PORT_W-1:0] multi_function_port_pins_in,
    output logic [PORT_W-1:0] mf_strong_lo,
    output logic [PORT_W-1:0] mf_strong_hi,
    output logic [PORT_W-1:0] mf_weak_hi,
    // Port 1 bit 7 pin
    input wire logic port1_bit7_pin,
    // Values seen by the core
    output logic [PORT_W-1:0] up_latch_r,
    output logic [PORT_W-1:0] mf_latch_r,
    output logic [PORT_W-1:0] up_pins_r,
    output logic [PORT_W-1:0] mf_pins_r,
    output logic [PORT_W-1:0] mf_alt_in_r,
    output logic ext_addr_fetch_r,
    output logic ext_irq5_input
);
    logic [PORT_W-1:0] up_s1_r;
    logic [PORT_W-1:0] mf_s1_r;
    logic irq_s1_r;
    logic irq_s2_r;
    logic irq_prev_r;
    logic [PORT_W-1:0] up_eff;
    logic [PORT_W-1:0] mf_eff;

    // Latches, reset to all ones
    always_ff @(posedge core_clk) begin
        if (reset) begin
            up_latch_r <= LATCH_RST;
            mf_latch_r <= LATCH_RST;
        end else begin
            if (up_wr) begin
                up_latch_r <= up_wdata;
            end
            if (mf_wr) begin
                mf_latch_r <= mf_wdata;
            end
        end
    end

    // Bus cycles take the upper port over regardless of the latch
    assign up_eff = ext_bus_active ? ext_addr_hi : up_latch_r;
    // Alternate output ANDed with latch, so a zero latch still pulls low
    assign mf_eff = mf_latch_r & ((mf_alt_out & mf_alt_en) | ~mf_alt_en);

    // Fetch or data cycle marker for the bus
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ext_addr_fetch_r <= 1'b0;
        end else begin
            ext_addr_fetch_r <= ext_bus_active && ext_bus_fetch;
        end
    end

    // Per-pin drivers
    for (genvar i = 0; i < PORT_W; i++) begin : g_pin
        qbp_pin u_up (
            .core_clk(core_clk),
            .reset(reset),
            .out_bit(up_eff[i]),
            .strong_lo(up_strong_lo[i]),
            .strong_hi(up_strong_hi[i]),
            .weak_hi(up_weak_hi[i])
        );
        qbp_pin u_mf (
            .core_clk(core_clk),
            .reset(reset),
            .out_bit(mf_eff[i]),
            .strong_lo(mf_strong_lo[i]),
            .strong_hi(mf_strong_hi[i]),
            .weak_hi(mf_weak_hi[i])
        );
    end

    // Pin synchronisers; read path works in any latch state
    always_ff @(posedge core_clk) begin
        if (reset) begin
            up_s1_r <= LATCH_RST;
            up_pins_r <= LATCH_RST;
            mf_s1_r <= LATCH_RST;
            mf_pins_r <= LATCH_RST;
        end else begin
            up_s1_r <= upper_address_port_pins_in;
            up_pins_r <= up_s1_r;
            mf_s1_r <= multi_function_port_pins_in;
            mf_pins_r <= mf_s1_r;
        end
    end

    // Alternate inputs seen only where the function is enabled
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mf_alt_in_r <= LATCH_RST;
        end else begin
            mf_alt_in_r <= mf_pins_r | ~mf_alt_en;
        end
    end

    // Interrupt 5 pin synchroniser and fall detect
    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_s1_r <= 1'b1;
            irq_s2_r <= 1'b1;
            irq_prev_r <= 1'b1;
            ext_irq5_input <= 1'b0;
        end else begin
            irq_s1_r <= port1_bit7_pin;
            irq_s2_r <= irq_s1_r;
            irq_prev_r <= irq_s2_r;
            ext_irq5_input <= irq_prev_r && !irq_s2_r;
        end
    end

    // Reset leaves latches high and only the weak pullups on
    // Checked from the first edge out of reset, while reset values still show
    AST_RESET_HIGH: assert property (@(posedge core_clk) disable iff (reset)
        $past(reset) |-> up_latch_r == LATCH_RST && mf_latch_r == LATCH_RST)
        else $error("latches not high after reset");
    AST_RESET_DRIVE: assert property (@(posedge core_clk) disable iff (reset)
        $past(reset) |-> up_weak_hi == LATCH_RST && mf_weak_hi == LATCH_RST
        && up_strong_lo == '0 && mf_strong_lo == '0 && up_strong_hi == '0 && mf_strong_hi == '0)
        else $error("pin drive not weak high after reset");

    // Zero writes show as a pulldown two edges after the strobe
    // Bus cycles are kept out, since they override the upper latch
    sequence mf_zero_wr_s;
        mf_wr && !mf_wdata[0] ##1 (!mf_wr) [*2];
    endsequence
    sequence up_zero_wr_s;
        up_wr && !up_wdata[7] && !ext_bus_active ##1 (!up_wr && !ext_bus_active) [*2];
    endsequence
    AST_PULLDOWN: assert property (@(posedge core_clk) disable iff (reset)
        mf_zero_wr_s |-> mf_strong_lo[0])
        else $error("pulldown missing after zero write");
    AST_UP_PULLDOWN: assert property (@(posedge core_clk) disable iff (reset)
        up_zero_wr_s |-> up_strong_lo[7])
        else $error("upper pulldown missing after zero write");

    // Bus cycles put the address byte on the upper port pins
    // A one bit is checked after two steady cycles; the drive already follows the address one edge after the first
    AST_ADDR: assert property (@(posedge core_clk) disable iff (reset)
        ext_bus_active && ext_addr_hi[1] && $past(ext_bus_active) && $past(ext_addr_hi[1])
        |=> !up_strong_lo[1])
        else $error("address byte not driven");
    AST_ADDR_LOW: assert property (@(posedge core_clk) disable iff (reset)
        ext_bus_active && !ext_addr_hi[0] |=> up_strong_lo[0])
        else $error("address zero not pulled low");
    AST_FETCH: assert property (@(posedge core_clk) disable iff (reset)
        ext_addr_fetch_r |-> $past(ext_bus_active))
        else $error("fetch marked without bus cycle");
    // Data cycles use the same bus and must not look like fetches
    AST_FETCH_DATA: assert property (@(posedge core_clk) disable iff (reset)
        ext_bus_active && !ext_bus_fetch |=> !ext_addr_fetch_r)
        else $error("data cycle marked as fetch");

    // Interrupt 5 fires once, one edge after the synchronised fall
    // The pulse trails the pin by three edges because of the synchroniser
    sequence irq_fall_s;
        irq_s2_r ##1 !irq_s2_r;
    endsequence
    AST_IRQ_LATENCY: assert property (@(posedge core_clk) disable iff (reset)
        irq_fall_s |=> ext_irq5_input)
        else $error("interrupt 5 missed a falling edge");
    AST_IRQ_FALL: assert property (@(posedge core_clk) disable iff (reset)
        ext_irq5_input |-> $past(irq_prev_r) && !$past(irq_s2_r))
        else $error("interrupt 5 not on a falling edge");
    AST_IRQ_PULSE: assert property (@(posedge core_clk) disable iff (reset)
        ext_irq5_input |=> !ext_irq5_input)
        else $error("interrupt 5 pulse too long");

    // Plain I/O bits keep the weak high input state
    // Alternate bits follow their function on both the input and output side
    AST_WEAK_INPUT: assert property (@(posedge core_clk) disable iff (reset)
        $past(mf_latch_r[1]) && !$past(mf_alt_en[1]) && $past(mf_latch_r[1], 2)
        && !$past(mf_alt_en[1], 2) |-> mf_weak_hi[1] && !mf_strong_lo[1])
        else $error("weak high input state lost");
    AST_ALT_LOW: assert property (@(posedge core_clk) disable iff (reset)
        !mf_alt_in_r[0] |-> $past(mf_alt_en[0]))
        else $error("alternate input low while disabled");
    // An alternate zero must win over a one in the latch
    AST_ALT_OUT: assert property (@(posedge core_clk) disable iff (reset)
        mf_alt_en[0] && !mf_alt_out[0] |=> mf_strong_lo[0])
        else $error("alternate zero not pulled low");
endmodule : quasi_bidir_port_pair
`default_nettype wire

// [verilog/qbp_pkg.sv]
// Constants for the quasi-bidirectional port pair.
// Assumes one core clock at 20 MHz and a machine cycle of four clocks.
`default_nettype none
package qbp_pkg;
    localparam int PORT_W = 8;
    localparam logic [7:0] LATCH_RST = 8'hff;
    localparam int CLK_MHZ = 20;
    localparam int MCYC_CLKS = 4;
    localparam int MCYC_NS = 200;
    // Strong high drive lasts one machine cycle
    localparam int KICK_CYC = ((MCYC_NS * CLK_MHZ) + 999) / 1000;
    localparam int KICK_W = 3;
    // Alternate function bit positions on the multi-function port
    localparam int ALT_RXD = 0;
    localparam int ALT_TXD = 1;
    localparam int ALT_INT0 = 2;
    localparam int ALT_INT1 = 3;
    localparam int ALT_T0 = 4;
    localparam int ALT_T1 = 5;
    localparam int ALT_WR = 6;
    localparam int ALT_RD = 7;
    localparam int IRQ5_BIT = 7;
endpackage : qbp_pkg
`default_nettype wire

// [verilog/qbp_pin.sv]
// One quasi-bidirectional pin: weak pullup, strong pulldown, one-shot high kick.
// Assumes the effective output bit comes from logic on the same clock.
`default_nettype none
module qbp_pin
    import qbp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Effective output level
    input wire logic out_bit,
    // Pin drive
    output logic strong_lo,
    output logic strong_hi,
    output logic weak_hi
);
    logic prev_r;
    logic [KICK_W-1:0] kick_r;

    // Previous output value, reset high
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= out_bit;
        end
    end

    // Kick timer starts on a rise after zero
    always_ff @(posedge core_clk) begin
        if (reset) begin
            kick_r <= '0;
        end else if (!out_bit) begin
            kick_r <= '0; // Kick cut short by a new zero
        end else if (!prev_r) begin
            kick_r <= KICK_W'(KICK_CYC);
        end else if (kick_r != '0) begin
            kick_r <= kick_r - 1'b1;
        end
    end

    // Drives registered so pins switch cleanly
    always_ff @(posedge core_clk) begin
        if (reset) begin
            strong_lo <= 1'b0;
            strong_hi <= 1'b0;
            weak_hi <= 1'b1;
        end else begin
            strong_lo <= !out_bit;
            strong_hi <= out_bit && (!prev_r || (kick_r > KICK_W'(1)));
            weak_hi <= out_bit;
        end
    end

    // Kick stands four edges while the output stays high; a new zero may cut it legally
    sequence kick_held_s;
        ($rose(strong_hi) && out_bit) ##1 out_bit [*2];
    endsequence
    AST_KICK_LEN: assert property (@(posedge core_clk) disable iff (reset)
        kick_held_s |=> ($past(strong_hi, 2) && $past(strong_hi) && strong_hi) ##1 !strong_hi)
        else $error("strong high drive length wrong");
    AST_NO_FIGHT: assert property (@(posedge core_clk) disable iff (reset)
        !(strong_lo && (strong_hi || weak_hi)))
        else $error("pulldown fights pullup");
endmodule : qbp_pin
`default_nettype wire

// [verification/qbp_pin_world.sv]
// Outside circuit model for one 8-bit quasi-bidirectional port.
// Assumes active-high drive enables from the port pair on core_clk.
`default_nettype none
module qbp_pin_world
    import qbp_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Port drive
    input wire logic [PORT_W-1:0] strong_lo,
    input wire logic [PORT_W-1:0] strong_hi,
    input wire logic [PORT_W-1:0] weak_hi,
    // Outside driver
    input wire logic [PORT_W-1:0] ext_en,
    input wire logic [PORT_W-1:0] ext_val,
    // Resolved level
    output logic [PORT_W-1:0] pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [PORT_W-1:0] last_r;
    // Floating bits show the inverse of the last level, so nothing reads kindly
    always_ff @(posedge core_clk) begin
        last_r <= pin;
    end
    // Strong drive wins; an outside driver beats the weak pullup
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            pin[i] = strong_lo[i] ? 1'b0 : strong_hi[i] ? 1'b1 : ext_en[i] ? ext_val[i] :
                     weak_hi[i] ? 1'b1 : ~last_r[i];
        end
    end
endmodule : qbp_pin_world
`default_nettype wire

// [verification/quasi_bidir_port_pair_bench.sv]
// Self-checking bench for the quasi-bidirectional port pair.
// Assumes the pin models above stand in for the outside world.
`default_nettype none
module quasi_bidir_port_pair_bench
    import qbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, reset = 1'b1, up_wr = 1'b0, mf_wr = 1'b0, bus_act = 1'b0, bus_fetch = 1'b0, p17 = 1'b1;
    logic [7:0] up_wdata = 8'h00, mf_wdata = 8'h00, addr_hi = 8'h00, alt_en = 8'h00, alt_out = 8'hff;
    logic [7:0] up_xen = 8'h00, mf_xen = 8'h00, mf_xval = 8'h00, up_pin, mf_pin;
    logic [7:0] up_lo, up_hi, up_wk, mf_lo, mf_hi, mf_wk, up_lat, mf_lat, up_pr, mf_pr, alt_in;
    logic fetch_r, irq5;
    int mismatches = 0, checks_done = 0;
    // 20 MHz core clock
    always #25 core_clk = ~core_clk;
    quasi_bidir_port_pair DUT (.core_clk(core_clk), .reset(reset), .up_wr(up_wr), .up_wdata(up_wdata),
        .mf_wr(mf_wr), .mf_wdata(mf_wdata), .ext_bus_active(bus_act), .ext_bus_fetch(bus_fetch),
        .ext_addr_hi(addr_hi), .mf_alt_en(alt_en), .mf_alt_out(alt_out), .upper_address_port_pins_in(up_pin),
        .up_strong_lo(up_lo), .up_strong_hi(up_hi), .up_weak_hi(up_wk), .multi_function_port_pins_in(mf_pin),
        .mf_strong_lo(mf_lo), .mf_strong_hi(mf_hi), .mf_weak_hi(mf_wk), .port1_bit7_pin(p17),
        .up_latch_r(up_lat), .mf_latch_r(mf_lat), .up_pins_r(up_pr), .mf_pins_r(mf_pr), .mf_alt_in_r(alt_in),
        .ext_addr_fetch_r(fetch_r), .ext_irq5_input(irq5));
    // Upper port world never drives low on its own, only overrides when enabled
    qbp_pin_world up_world (.core_clk(core_clk), .strong_lo(up_lo), .strong_hi(up_hi), .weak_hi(up_wk),
        .ext_en(up_xen), .ext_val(8'h00), .pin(up_pin));
    qbp_pin_world mf_world (.core_clk(core_clk), .strong_lo(mf_lo), .strong_hi(mf_hi), .weak_hi(mf_wk),
        .ext_en(mf_xen), .ext_val(mf_xval), .pin(mf_pin));
    // Compare and count
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Settled sampling point
    task tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick
    // One-cycle write strobe on the multi-function port
    task mf_write(input logic [7:0] d);
        @(posedge core_clk);
        mf_wr <= 1'b1;
        mf_wdata <= d;
        @(posedge core_clk);
        mf_wr <= 1'b0;
    endtask : mf_write
    // One-cycle write strobe on the upper address port
    task up_write(input logic [7:0] d);
        @(posedge core_clk);
        up_wr <= 1'b1;
        up_wdata <= d;
        @(posedge core_clk);
        up_wr <= 1'b0;
    endtask : up_write
    task t_reset;
        check("latches", {up_lat & mf_lat}, LATCH_RST);
        check("weak", up_wk & mf_wk, 8'hff);
        check("strong", up_lo | up_hi | mf_lo | mf_hi, 8'h00);
    endtask : t_reset
    // Zero then one: pulldown stays, then a kick of one machine cycle
    task t_kick;
        int n;
        mf_write(8'h00);
        tick(6);
        check("pulldown", mf_lo, 8'hff);
        check("mf latch", mf_lat, 8'h00);
        check("pins low", mf_pr, 8'h00);
        mf_write(8'hff);
        n = 0;
        for (int i = 0; i < 12; i++) begin
            tick(1);
            n += mf_hi[3];
        end
        check("kick length", n[7:0], KICK_CYC[7:0]);
        check("after kick", {mf_hi | mf_lo}, 8'h00);
        check("weak back", mf_wk, 8'hff);
    endtask : t_kick
    // Outside driver overrides the weak high and reads back as input
    task t_input;
        @(posedge core_clk);
        mf_xen <= 8'hff;
        mf_xval <= 8'h3c;
        up_xen <= 8'hf0;
        tick(3);
        check("mf input", mf_pr, 8'h3c);
        check("up input", up_pr, 8'h0f);
        @(posedge core_clk);
        alt_en <= 8'h0f;
        tick(3);
        check("alt in", alt_in, 8'hfc);
        @(posedge core_clk);
        mf_xen <= 8'h00;
        up_xen <= 8'h00;
        alt_out <= 8'hfe;
        tick(3);
        check("alt out", mf_lo, 8'h01);
        @(posedge core_clk);
        alt_en <= 8'h00;
    endtask : t_input
    // External bus cycle puts the high address byte on the upper port
    task t_bus(input logic f);
        @(posedge core_clk);
        bus_act <= 1'b1;
        bus_fetch <= f;
        addr_hi <= 8'h5a;
        tick(4);
        check("addr drive", up_lo, 8'ha5);
        check("fetch flag", {7'h00, fetch_r}, {7'h00, f});
        check("addr pins", up_pr, 8'h5a);
        @(posedge core_clk);
        bus_act <= 1'b0;
    endtask : t_bus
    // Only the falling edge of port 1 bit 7 raises interrupt 5
    task t_irq(input logic lvl, input logic [7:0] exp);
        int n;
        n = 0;
        @(posedge core_clk);
        p17 <= lvl;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            n += irq5;
        end
        check("irq pulses", n[7:0], exp);
    endtask : t_irq
    // Upper port: zero bits pull down, only they kick high when set again
    task t_up;
        int n;
        logic [7:0] acc;
        up_write(8'h0f);
        tick(4);
        check("up latch", up_lat, 8'h0f);
        check("up pulldown", up_lo, 8'hf0);
        check("up weak", up_wk, 8'h0f);
        check("up pins", up_pr, 8'h0f);
        up_write(8'hff);
        n = 0;
        acc = 8'h00;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            n += up_hi[7];
            acc = acc | up_hi;
        end
        check("up kick", n[7:0], KICK_CYC[7:0]);
        check("up kick bits", acc, 8'hf0);
        check("up after kick", up_hi | up_lo, 8'h00);
    endtask : t_up
    // Reset in mid-run drops a held pulldown and leaves only the weak pullups
    task t_rst_mid;
        mf_write(8'h00);
        tick(3);
        check("held low", mf_lo, 8'hff);
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        tick(1);
        check("mid latches", up_lat & mf_lat, LATCH_RST);
        check("mid drive", mf_lo | mf_hi, 8'h00);
        tick(4);
        check("mid no kick", mf_lo | mf_hi, 8'h00);
        check("mid weak", mf_wk, 8'hff);
    endtask : t_rst_mid
    task close_out;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        tick(1);
        t_reset();
        t_kick();
        t_input();
        t_up();
        t_bus(1'b1);
        t_bus(1'b0);
        t_irq(1'b0, 8'h01);
        t_irq(1'b1, 8'h00);
        t_rst_mid();
        close_out();
    end
endmodule : quasi_bidir_port_pair_bench
`default_nettype wire
